// ### hw/sme_exec.sv
// Decode and execute of condition, state and special register moves
//
// Functional notes
// RULE1 - Field move copies source condition field into destination field, others kept.
// RULE2 - Exception-to-condition move loads exception bits 0:3, then clears them.
// RULE3 - Condition register read returns all 32 bits, never raises exception.
// RULE4 - Device control read returns the register selected by assembled number.
// RULE5 - Device control and time-base numbers swap the two 5-bit halves.
// RULE6 - Device control and machine state reads fault in user mode.
// RULE7 - Machine state read copies the state register into destination.
// RULE8 - Special register read copies the selected register into destination.
// RULE9 - Special number is split bits 5:9 over split bits 0:4.
// RULE10 - User-mode special read faults only when the first split bit is one.
// RULE11 - Time-base read returns lower word at 268, upper at 269, unprivileged.
// RULE12 - Non-zero reserved bits give an undefined result, never an exception.
// RULE13 - Unsupported register numbers give an undefined result, never an exception.
// RULE14 - Opcode, destination, split field and extended opcode at big-endian positions.
`timescale 1ns/1ns
module sme_exec #(
  parameter int DCR_WAIT = sme_pkg::DCR_WAIT_CYCLES  // Device control read timeout
) (
  input  wire logic                            clock,          // Core clock
  input  wire logic                            sys_rst,        // Synchronous reset
  input  wire logic                            instr_valid,    // Instruction offered
  input  wire logic [sme_pkg::WORD_W-1:0]      instr_word,     // Instruction word
  output logic                                 instr_ready,    // Can accept
  output logic                                 instr_hit,      // Opcode handled here
  input  wire logic                            user_mode,      // Problem state
  input  wire logic [sme_pkg::WORD_W-1:0]      machine_state_reg, // State register
  output logic      [sme_pkg::REGNUM_W-1:0]    special_reg_number, // Special number
  input  wire logic [sme_pkg::WORD_W-1:0]      special_reg_rdata,  // Special data
  output logic      [sme_pkg::REGNUM_W-1:0]    device_control_number, // Device number
  output logic                                 dcr_rd_req,     // Device read request
  input  wire logic                            dcr_rd_ack,     // Device read done
  input  wire logic [sme_pkg::WORD_W-1:0]      dcr_rdata,      // Device read data
  input  wire logic                            tb_tick,        // Time base enable
  input  wire logic                            cr_load_en,     // External CR load
  input  wire logic [sme_pkg::WORD_W-1:0]      cr_load_data,   // External CR value
  input  wire logic                            xer_sum_load_en,   // External load
  input  wire logic [sme_pkg::NIBBLE_W-1:0]    xer_sum_load_data, // External value
  output logic                                 gpr_wr_en,      // Writeback pulse
  output logic      [sme_pkg::GPR_IDX_W-1:0]   gpr_wr_addr,    // Writeback index
  output logic      [sme_pkg::WORD_W-1:0]      gpr_wr_data,    // Writeback data
  output logic                                 prog_exc,       // Program exception
  output logic                                 done,           // Instruction retired
  output logic      [sme_pkg::WORD_W-1:0]      condition_reg,  // Condition register
  output logic      [sme_pkg::NIBBLE_W-1:0]    xer_summary     // Exception bits 0:3
);
  import sme_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  // Read condition field n (big-endian bits 4n..4n+3)
  function automatic logic [NIBBLE_W-1:0] cr_get(input logic [WORD_W-1:0]      cr,
                                                 input logic [FIELD_IDX_W-1:0] n);
    logic [NIBBLE_W-1:0] v;
    v = XER_SUM_CLEAR;
    for (int i = 0; i < CR_FIELDS; i++) begin
      if (n == FIELD_IDX_W'(i)) begin
        v = cr[WORD_W-1-NIBBLE_W*i -: NIBBLE_W];
      end
    end
    return v;
  endfunction

  // Replace condition field n, leaving the others untouched
  function automatic logic [WORD_W-1:0] cr_put(input logic [WORD_W-1:0]      cr,
                                               input logic [FIELD_IDX_W-1:0] n,
                                               input logic [NIBBLE_W-1:0]    v);
    logic [WORD_W-1:0] r;
    r = cr;
    for (int i = 0; i < CR_FIELDS; i++) begin
      if (n == FIELD_IDX_W'(i)) begin
        r[WORD_W-1-NIBBLE_W*i -: NIBBLE_W] = v;
      end
    end
    return r;
  endfunction

  localparam int CNT_W = $clog2(DCR_WAIT + 1);

  ////////////////////////////////////////////////////////////////////////////
  // Decode

  logic [PRI_W-1:0]       primary_op;
  logic [EXT_W-1:0]       extended_op;
  logic [GPR_IDX_W-1:0]   dest_gpr;
  logic [FIELD_IDX_W-1:0] dest_cond_field_sel;
  logic [FIELD_IDX_W-1:0] src_cond_field_sel;
  logic [REGNUM_W-1:0]    reg_number;
  logic                   split_top_bit;
  logic [WORD_W-1:0]      tb_lower;
  logic [WORD_W-1:0]      tb_upper;

  sme_field_dec u_dec (
    .instr_word          (instr_word),
    .primary_op          (primary_op),
    .extended_op         (extended_op),
    .dest_gpr            (dest_gpr),
    .dest_cond_field_sel (dest_cond_field_sel),
    .src_cond_field_sel  (src_cond_field_sel),
    .reg_number          (reg_number),
    .split_top_bit       (split_top_bit)
  );

  sme_time_base u_tb (
    .clock    (clock),
    .sys_rst  (sys_rst),
    .tb_tick  (tb_tick),
    .tb_lower (tb_lower),
    .tb_upper (tb_upper)
  );

  ////////////////////////////////////////////////////////////////////////////
  // State

  sme_state_t             state_r;
  sme_state_t             state_nxt;
  logic [CNT_W-1:0]       wait_cnt_r;
  logic [CNT_W-1:0]       wait_cnt_nxt;
  logic [GPR_IDX_W-1:0]   pend_gpr_r;
  logic [GPR_IDX_W-1:0]   pend_gpr_nxt;
  logic [REGNUM_W-1:0]    dcr_num_r;
  logic [REGNUM_W-1:0]    dcr_num_nxt;
  logic [WORD_W-1:0]      cr_r;
  logic [WORD_W-1:0]      cr_nxt;
  logic [NIBBLE_W-1:0]    xer_r;
  logic [NIBBLE_W-1:0]    xer_nxt;
  logic                   wr_en_r;
  logic                   wr_en_nxt;
  logic [GPR_IDX_W-1:0]   wr_addr_r;
  logic [GPR_IDX_W-1:0]   wr_addr_nxt;
  logic [WORD_W-1:0]      wr_data_r;
  logic [WORD_W-1:0]      wr_data_nxt;
  logic                   exc_r;
  logic                   exc_nxt;
  logic                   done_r;
  logic                   done_nxt;

  logic                   accept;
  logic                   is_field_move;
  logic                   is_ext;

  always_comb begin
    is_field_move = (primary_op == OP_COND_LOGIC) && (extended_op == EXT_FIELD_MOVE);
    is_ext        = (primary_op == OP_EXTENDED) &&
                    ((extended_op == EXT_XER_TO_CR) || (extended_op == EXT_READ_CR) ||
                     (extended_op == EXT_READ_DCR)  || (extended_op == EXT_READ_MSR) ||
                     (extended_op == EXT_READ_SPR)  || (extended_op == EXT_READ_TB));
    instr_hit     = is_field_move || is_ext;
    instr_ready   = (state_r == SME_IDLE);
    accept        = instr_valid && instr_ready && instr_hit;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state and execute

  always_comb begin
    state_nxt    = state_r;
    wait_cnt_nxt = wait_cnt_r;
    pend_gpr_nxt = pend_gpr_r;
    dcr_num_nxt  = dcr_num_r;
    cr_nxt       = cr_r;
    xer_nxt      = xer_r;
    wr_en_nxt    = 1'b0;
    wr_addr_nxt  = wr_addr_r;
    wr_data_nxt  = wr_data_r;
    exc_nxt      = 1'b0;
    done_nxt     = 1'b0;
    // Reserved bits are never inspected, so they cannot fault  [RULE12]
    case (state_r)
      SME_IDLE: begin
        if (accept) begin
          done_nxt    = 1'b1;
          wr_addr_nxt = dest_gpr;
          if (is_field_move) begin
            cr_nxt = cr_put(cr_r, dest_cond_field_sel,
                            cr_get(cr_r, src_cond_field_sel));           // [RULE1]
          end else begin
            case (extended_op)
              EXT_XER_TO_CR: begin
                cr_nxt  = cr_put(cr_r, dest_cond_field_sel, xer_r);     // [RULE2]
                xer_nxt = XER_SUM_CLEAR;                                // [RULE2]
              end
              EXT_READ_CR: begin
                wr_en_nxt   = 1'b1;                                     // [RULE3]
                wr_data_nxt = cr_r;                                     // [RULE3]
              end
              EXT_READ_MSR: begin
                if (user_mode) begin
                  exc_nxt = 1'b1;                                       // [RULE6]
                end else begin
                  wr_en_nxt   = 1'b1;                                   // [RULE7]
                  wr_data_nxt = machine_state_reg;                      // [RULE7]
                end
              end
              EXT_READ_SPR: begin
                if (user_mode && split_top_bit) begin
                  exc_nxt = 1'b1;                                       // [RULE10]
                end else begin
                  wr_en_nxt   = 1'b1;                                   // [RULE8]
                  wr_data_nxt = special_reg_rdata;                      // [RULE8] [RULE13]
                end
              end
              EXT_READ_TB: begin
                wr_en_nxt = 1'b1;                                       // [RULE11]
                if (reg_number == TBN_LOWER) begin
                  wr_data_nxt = tb_lower;                               // [RULE11]
                end else if (reg_number == TBN_UPPER) begin
                  wr_data_nxt = tb_upper;                               // [RULE11]
                end else begin
                  wr_data_nxt = WORD_ZERO;                              // [RULE13]
                end
              end
              EXT_READ_DCR: begin
                if (user_mode) begin
                  exc_nxt = 1'b1;                                       // [RULE6]
                end else begin
                  // Retire later, when the device bus answers or the DCR_WAIT timeout runs out
                  done_nxt     = 1'b0;
                  state_nxt    = SME_DCR_WAIT;
                  wait_cnt_nxt = CNT_W'(DCR_WAIT);
                  pend_gpr_nxt = dest_gpr;
                  dcr_num_nxt  = reg_number;                            // [RULE5]
                end
              end
              default: begin
                done_nxt = 1'b0;
              end
            endcase
          end
        end
      end
      SME_DCR_WAIT: begin
        if (dcr_rd_ack) begin
          wr_en_nxt   = 1'b1;                                           // [RULE4]
          wr_data_nxt = dcr_rdata;                                      // [RULE4]
          wr_addr_nxt = pend_gpr_r;
          done_nxt    = 1'b1;
          state_nxt   = SME_IDLE;
        end else if (wait_cnt_r == CNT_W'(1)) begin
          // Nobody answered: unsupported number, undefined data, no fault
          wr_en_nxt   = 1'b1;                                           // [RULE13]
          wr_data_nxt = WORD_ZERO;
          wr_addr_nxt = pend_gpr_r;
          done_nxt    = 1'b1;
          state_nxt   = SME_IDLE;
        end else begin
          wait_cnt_nxt = wait_cnt_r - CNT_W'(1);
        end
      end
      default: begin
        state_nxt = SME_IDLE;
      end
    endcase
    // Loads from the rest of the pipeline win over this block's updates
    if (cr_load_en) begin
      cr_nxt = cr_load_data;
    end
    if (xer_sum_load_en) begin
      xer_nxt = xer_sum_load_data;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Registers

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state_r    <= SME_IDLE;
      wait_cnt_r <= '0;
      pend_gpr_r <= '0;
      dcr_num_r  <= '0;
      cr_r       <= CR_RESET;
      xer_r      <= XER_SUM_RESET;
      wr_en_r    <= 1'b0;
      wr_addr_r  <= '0;
      wr_data_r  <= WORD_ZERO;
      exc_r      <= 1'b0;
      done_r     <= 1'b0;
    end else begin
      state_r    <= state_nxt;
      wait_cnt_r <= wait_cnt_nxt;
      pend_gpr_r <= pend_gpr_nxt;
      dcr_num_r  <= dcr_num_nxt;
      cr_r       <= cr_nxt;
      xer_r      <= xer_nxt;
      wr_en_r    <= wr_en_nxt;
      wr_addr_r  <= wr_addr_nxt;
      wr_data_r  <= wr_data_nxt;
      exc_r      <= exc_nxt;
      done_r     <= done_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign special_reg_number    = reg_number;                            // [RULE9]
  assign device_control_number = dcr_num_r;
  assign dcr_rd_req            = (state_r == SME_DCR_WAIT);
  assign gpr_wr_en             = wr_en_r;
  assign gpr_wr_addr           = wr_addr_r;
  assign gpr_wr_data           = wr_data_r;
  assign prog_exc              = exc_r;
  assign done                  = done_r;
  assign condition_reg         = cr_r;
  assign xer_summary           = xer_r;

endmodule

// ### hw/sme_pkg.sv
// Constants, types and helpers shared by the register-move execute block
package sme_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Widths
  localparam int WORD_W      = 32;
  localparam int GPR_IDX_W   = 5;
  localparam int FIELD_IDX_W = 3;
  localparam int NIBBLE_W    = 4;
  localparam int CR_FIELDS   = 8;
  localparam int PRI_W       = 6;
  localparam int EXT_W       = 10;
  localparam int REGNUM_W    = 10;
  localparam int HALF_W      = 5;
  localparam int TB_W        = 64;

  ////////////////////////////////////////////////////////////////////////////
  // Field positions; big-endian bit k of the instruction is word bit 31-k
  localparam int POS_PRI_MSB   = 31;
  localparam int POS_PRI_LSB   = 26;
  localparam int POS_RD_MSB    = 25;
  localparam int POS_RD_LSB    = 21;
  localparam int POS_DEST_COND_FIELD_SEL_MSB  = 25;
  localparam int POS_DEST_COND_FIELD_SEL_LSB  = 23;
  localparam int POS_SRC_COND_FIELD_SEL_MSB  = 20;
  localparam int POS_SRC_COND_FIELD_SEL_LSB  = 18;
  localparam int POS_SPLIT_MSB = 20;
  localparam int POS_SPLIT_LSB = 11;
  localparam int POS_EXT_MSB   = 10;
  localparam int POS_EXT_LSB   = 1;
  localparam int POS_SPLIT_TOP = 20;
  localparam int POS_XER_MSB   = 31;

  ////////////////////////////////////////////////////////////////////////////
  // Opcodes
  localparam logic [PRI_W-1:0] OP_COND_LOGIC = 6'h13;
  localparam logic [PRI_W-1:0] OP_EXTENDED   = 6'h1F;
  localparam logic [EXT_W-1:0] EXT_FIELD_MOVE = 10'h000;
  localparam logic [EXT_W-1:0] EXT_XER_TO_CR  = 10'h200;
  localparam logic [EXT_W-1:0] EXT_READ_CR    = 10'h013;
  localparam logic [EXT_W-1:0] EXT_READ_DCR   = 10'h143;
  localparam logic [EXT_W-1:0] EXT_READ_MSR   = 10'h053;
  localparam logic [EXT_W-1:0] EXT_READ_SPR   = 10'h153;
  localparam logic [EXT_W-1:0] EXT_READ_TB    = 10'h173;

  ////////////////////////////////////////////////////////////////////////////
  // Time-base register numbers
  localparam logic [REGNUM_W-1:0] TBN_LOWER = 10'h10C;
  localparam logic [REGNUM_W-1:0] TBN_UPPER = 10'h10D;

  ////////////////////////////////////////////////////////////////////////////
  // Reset values and timing
  localparam logic [WORD_W-1:0]   CR_RESET      = 32'h0000_0000;
  localparam logic [NIBBLE_W-1:0] XER_SUM_RESET = 4'h0;
  localparam logic [NIBBLE_W-1:0] XER_SUM_CLEAR = 4'h0;
  localparam logic [WORD_W-1:0]   WORD_ZERO     = 32'h0000_0000;
  localparam logic [TB_W-1:0]     TB_RESET      = 64'h0000_0000_0000_0000;
  localparam logic [TB_W-1:0]     TB_ONE        = 64'h0000_0000_0000_0001;
  localparam int                  DCR_WAIT_CYCLES = 16;

  ////////////////////////////////////////////////////////////////////////////
  // Execute state, Gray coded
  typedef enum logic [1:0] {
    SME_IDLE     = 2'h0,
    SME_DCR_WAIT = 2'h1
  } sme_state_t;

  // Swap the two 5-bit halves of a split register field
  function automatic logic [REGNUM_W-1:0] sme_swap_halves(input logic [REGNUM_W-1:0] f);
    sme_swap_halves = {f[HALF_W-1:0], f[REGNUM_W-1:HALF_W]};
  endfunction

endpackage

// ### hw/sme_field_dec.sv
// Instruction field extraction for the register-move execute block
`timescale 1ns/1ns
module sme_field_dec (
  input  wire logic [sme_pkg::WORD_W-1:0]      instr_word,   // Instruction word
  output logic      [sme_pkg::PRI_W-1:0]       primary_op,   // Primary opcode
  output logic      [sme_pkg::EXT_W-1:0]       extended_op,  // Extended opcode
  output logic      [sme_pkg::GPR_IDX_W-1:0]   dest_gpr,     // Destination register
  output logic      [sme_pkg::FIELD_IDX_W-1:0] dest_cond_field_sel, // Target field
  output logic      [sme_pkg::FIELD_IDX_W-1:0] src_cond_field_sel,  // Source field
  output logic      [sme_pkg::REGNUM_W-1:0]    reg_number,   // Assembled number
  output logic                                 split_top_bit // First split bit
);
  import sme_pkg::*;

  logic [REGNUM_W-1:0] split_field;

  always_comb begin
    primary_op          = instr_word[POS_PRI_MSB:POS_PRI_LSB];           // [RULE14]
    dest_gpr            = instr_word[POS_RD_MSB:POS_RD_LSB];             // [RULE14]
    extended_op         = instr_word[POS_EXT_MSB:POS_EXT_LSB];           // [RULE14]
    dest_cond_field_sel = instr_word[POS_DEST_COND_FIELD_SEL_MSB:POS_DEST_COND_FIELD_SEL_LSB];
    src_cond_field_sel  = instr_word[POS_SRC_COND_FIELD_SEL_MSB:POS_SRC_COND_FIELD_SEL_LSB];
    // Word bits 20:16 are split bits 0:4, word bits 15:11 are split bits 5:9
    split_field         = instr_word[POS_SPLIT_MSB:POS_SPLIT_LSB];       // [RULE14]
    reg_number          = sme_swap_halves(split_field);                  // [RULE5] [RULE9]
    split_top_bit       = instr_word[POS_SPLIT_TOP];
  end

endmodule

// ### hw/sme_time_base.sv
// 64-bit time base counter, advancing by one on each cycle with tb_tick high
`timescale 1ns/1ns
module sme_time_base (
  input  wire logic                      clock,     // Core clock
  input  wire logic                      sys_rst,   // Synchronous reset
  input  wire logic                      tb_tick,   // Count enable pulse
  output logic      [sme_pkg::WORD_W-1:0] tb_lower, // Lower word
  output logic      [sme_pkg::WORD_W-1:0] tb_upper  // Upper word
);
  import sme_pkg::*;

  logic [TB_W-1:0] count_r;
  logic [TB_W-1:0] count_nxt;

  always_comb begin
    count_nxt = count_r;
    if (tb_tick) begin
      count_nxt = count_r + TB_ONE;
    end
  end

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      count_r <= TB_RESET;
    end else begin
      count_r <= count_nxt;
    end
  end

  assign tb_lower = count_r[WORD_W-1:0];
  assign tb_upper = count_r[TB_W-1:WORD_W];

endmodule

// ### verif/sme_exec_checker.sv
// Port-level checks for the register-move execute block
`timescale 1ns/1ns
module sme_exec_checker #(
  parameter int DCR_WAIT = 16  // Device read timeout
) (
  input logic        clock,                 // Core clock
  input logic        sys_rst,               // Synchronous reset
  input logic        instr_valid,           // Offered
  input logic [31:0] instr_word,            // Instruction
  input logic        instr_ready,           // Can accept
  input logic        instr_hit,             // Handled form
  input logic        user_mode,             // Problem state
  input logic [9:0]  special_reg_number,    // Special number
  input logic [9:0]  device_control_number, // Device number
  input logic        dcr_rd_req,            // Read pending
  input logic        dcr_rd_ack,            // Read done
  input logic [31:0] dcr_rdata,             // Device data
  input logic        cr_load_en,            // CR load
  input logic        xer_sum_load_en,       // Summary load
  input logic        gpr_wr_en,             // Write pulse
  input logic [4:0]  gpr_wr_addr,           // Write index
  input logic [31:0] gpr_wr_data,           // Write data
  input logic        prog_exc,              // Exception
  input logic        done,                  // Retired
  input logic [31:0] condition_reg,         // Condition register
  input logic [3:0]  xer_summary            // Exception bits 0:3
);
  import sme_pkg::*;
  localparam int WAIT_MAX = DCR_WAIT + 2;
  logic       acc;
  logic       xo;
  logic [9:0] ext;
  assign acc = instr_valid && instr_ready && instr_hit;
  assign xo  = instr_word[31:26] == OP_EXTENDED;
  assign ext = instr_word[10:1];
  function automatic logic [3:0] nib(input logic [31:0] c, input logic [2:0] n);
    return c[31 - 4*n -: 4];
  endfunction
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  ////////////////////////////////////////////////////////////////////////////
  field_move_a: assert property (acc && instr_word[31:26] == OP_COND_LOGIC && !cr_load_en
    |=> !gpr_wr_en && nib(condition_reg, $past(instr_word[25:23]))
        == nib($past(condition_reg), $past(instr_word[20:18]))) else $error("field move");
  xer_move_a: assert property (acc && xo && ext == EXT_XER_TO_CR && !cr_load_en
    && !xer_sum_load_en |=> xer_summary == 4'h0
    && nib(condition_reg, $past(instr_word[25:23])) == $past(xer_summary)) else $error("xer move");
  cr_read_a: assert property (acc && xo && ext == EXT_READ_CR |=> done && gpr_wr_en
    && !prog_exc && gpr_wr_data == $past(condition_reg)
    && gpr_wr_addr == $past(instr_word[25:21])) else $error("cr read");
  dcr_start_a: assert property (acc && xo && ext == EXT_READ_DCR && !user_mode
    |=> dcr_rd_req && !instr_ready && !done && device_control_number
        == {$past(instr_word[15:11]), $past(instr_word[20:16])}) else $error("dcr start");
  dcr_data_a: assert property (dcr_rd_req && dcr_rd_ack
    |=> done && gpr_wr_en && !dcr_rd_req && gpr_wr_data == $past(dcr_rdata)) else $error("dcr data");
  dcr_bound_a: assert property ($rose(dcr_rd_req) |-> ##[1:WAIT_MAX] !dcr_rd_req)
    else $error("dcr wait too long");
  priv_fault_a: assert property (acc && xo && user_mode && (ext == EXT_READ_DCR
    || ext == EXT_READ_MSR) |=> prog_exc && done && !gpr_wr_en && !dcr_rd_req)
    else $error("privileged read");
  spr_num_a: assert property (special_reg_number
    == {instr_word[15:11], instr_word[20:16]}) else $error("special number");
  spr_priv_a: assert property (acc && xo && ext == EXT_READ_SPR |=> done
    && prog_exc == ($past(user_mode) && $past(instr_word[20])) && gpr_wr_en == !prog_exc)
    else $error("special privilege");
endmodule

bind sme_exec sme_exec_checker #(.DCR_WAIT(DCR_WAIT)) u_chk (.*);

// ### verif/sme_dev_model.sv
// Far-side model: device bus responder and special data
`timescale 1ns/1ns
module sme_dev_model (
  input  logic        clock,      // Core clock
  input  logic        sys_rst,    // Synchronous reset
  input  logic        dcr_rd_req, // Read pending
  input  logic [9:0]  dcr_num,    // Device number
  input  logic [9:0]  spr_num,    // Special number
  input  logic [7:0]  ack_delay,  // Cycles to answer
  output logic        dcr_rd_ack, // Answer pulse
  output logic [31:0] dcr_rdata,  // Answer data
  output logic [31:0] spr_rdata   // Special data
);
  logic [7:0]  cnt_r, cnt_nxt;
  logic        ack_r, ack_nxt;
  logic [31:0] val;
  always_comb begin
    cnt_nxt = 8'h00;
    ack_nxt = 1'b0;
    if (dcr_rd_req && !ack_r) begin
      cnt_nxt = cnt_r + 8'h01;
      ack_nxt = cnt_nxt == ack_delay;
    end
  end
  always_ff @(posedge clock) begin
    cnt_r <= sys_rst ? 8'h00 : cnt_nxt;
    ack_r <= sys_rst ? 1'b0 : ack_nxt;
  end
  assign val        = 32'h5A5A_0000 | {22'h0, dcr_num};
  assign dcr_rd_ack = ack_r;
  // Stale data shows inverted
  assign dcr_rdata  = ack_r ? val : ~val;
  assign spr_rdata  = 32'hC0DE_0000 | {22'h0, spr_num};
endmodule

// ### verif/sme_exec_tb.sv
// Self-checking bench for the register-move execute block
`timescale 1ns/1ns
module sme_exec_tb;
  import sme_pkg::*;
  localparam logic [31:0] MSR_V = 32'h0002_1030;
  logic        clock, sys_rst, instr_valid, instr_ready, instr_hit, user_mode, tb_tick;
  logic        dcr_rd_req, dcr_rd_ack, cr_load_en, xer_sum_load_en, gpr_wr_en, prog_exc, done;
  logic        r_exc, r_wr;
  logic [31:0] instr_word, machine_state_reg, special_reg_rdata, dcr_rdata, cr_load_data;
  logic [31:0] gpr_wr_data, condition_reg, r_data;
  logic [9:0]  special_reg_number, device_control_number;
  logic [4:0]  gpr_wr_addr, r_addr;
  logic [3:0]  xer_sum_load_data, xer_summary;
  logic [7:0]  ack_delay;
  int          fails = 0, checks_done = 0;
  sme_exec #(.DCR_WAIT(4)) uut (.*);
  sme_dev_model u_dev (.clock, .sys_rst, .dcr_rd_req, .dcr_num(device_control_number),
    .spr_num(special_reg_number), .ack_delay, .dcr_rd_ack, .dcr_rdata,
    .spr_rdata(special_reg_rdata));
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  ////////////////////////////////////////////////////////////////////////////
  function automatic logic [31:0] enc(input logic [5:0] p, input logic [4:0] r,
                                      input logic [9:0] n, input logic [9:0] x);
    return {p, r, n[4:0], n[9:5], x, 1'b0};
  endfunction
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fails++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, fails);
    if (fails == 0 && checks_done > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  // Offer one instruction, then wait for it to retire
  task automatic run(input logic [31:0] w, input logic um);
    int n;
    @(posedge clock);
    instr_valid <= 1'b1;
    instr_word  <= w;
    user_mode   <= um;
    @(posedge clock);
    instr_valid <= 1'b0;
    for (n = 0; n < 20; n++) begin
      @(negedge clock);
      if (done === 1'b1) break;
    end
    if (n == 20) begin
      fails++;
      end_sim();
    end
    {r_exc, r_wr, r_data, r_addr} = {prog_exc, gpr_wr_en, gpr_wr_data, gpr_wr_addr};
  endtask
  task automatic rd(input logic [9:0] x, input logic [9:0] n, input logic um,
                    input logic exc, input logic [31:0] exp);
    run(enc(OP_EXTENDED, 5'd9, n, x), um);
    chk("fault", {31'h0, r_exc}, {31'h0, exc});
    chk("write", {31'h0, r_wr}, {31'h0, !exc});
    if (!exc) chk("data", r_data, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_cr();
    @(negedge clock);
    chk("reset cr", condition_reg, 32'h0);
    @(posedge clock);
    cr_load_en        <= 1'b1;
    cr_load_data      <= 32'h1234_5678;
    xer_sum_load_en   <= 1'b1;
    xer_sum_load_data <= 4'hB;
    @(posedge clock);
    cr_load_en      <= 1'b0;
    xer_sum_load_en <= 1'b0;
    run(enc(OP_COND_LOGIC, 5'h18, 10'h004, EXT_FIELD_MOVE), 1'b0);
    chk("mcrf", condition_reg, 32'h1234_5628);
    chk("mcrf wr", {31'h0, r_wr | r_exc}, 32'h0);
    run(enc(OP_COND_LOGIC, 5'h00, 10'h01C, EXT_FIELD_MOVE) | 32'h1, 1'b0);
    chk("mcrf rsv", condition_reg, 32'h8234_5628);
    run(enc(OP_EXTENDED, 5'h0C, 10'h000, EXT_XER_TO_CR), 1'b0);
    chk("mcrxr", condition_reg, 32'h823B_5628);
    chk("summary", {28'h0, xer_summary}, 32'h0);
    run(enc(OP_EXTENDED, 5'd17, 10'h000, EXT_READ_CR) | 32'h0000_F800, 1'b1);
    chk("mfcr", r_data, 32'h823B_5628);
    chk("mfcr rd", {27'h0, r_addr}, 32'd17);
    chk("mfcr exc", {31'h0, r_exc}, 32'h0);
    $display("condition moves finished");
  endtask
  task automatic t_reads();
    rd(EXT_READ_MSR, 10'h000, 1'b0, 1'b0, MSR_V);
    rd(EXT_READ_MSR, 10'h000, 1'b1, 1'b1, 32'h0);
    rd(EXT_READ_SPR, 10'h3F0, 1'b0, 1'b0, 32'hC0DE_03F0);
    rd(EXT_READ_SPR, 10'h3F0, 1'b1, 1'b1, 32'h0);
    rd(EXT_READ_SPR, 10'h008, 1'b1, 1'b0, 32'hC0DE_0008);
    $display("state and special reads finished");
  endtask
  task automatic t_dcr();
    rd(EXT_READ_DCR, 10'h2A5, 1'b0, 1'b0, 32'h5A5A_02A5);
    rd(EXT_READ_DCR, 10'h2A5, 1'b1, 1'b1, 32'h0);
    ack_delay <= 8'hFF;
    rd(EXT_READ_DCR, 10'h2A5, 1'b0, 1'b0, 32'h0);
    $display("device reads finished");
  endtask
  task automatic t_tb();
    @(posedge clock);
    tb_tick <= 1'b1;
    repeat (5) @(posedge clock);
    tb_tick <= 1'b0;
    rd(EXT_READ_TB, TBN_LOWER, 1'b1, 1'b0, 32'h5);
    rd(EXT_READ_TB, TBN_UPPER, 1'b1, 1'b0, 32'h0);
    rd(EXT_READ_TB, 10'h10E, 1'b1, 1'b0, 32'h0);
    $display("time base reads finished");
  endtask
  initial begin
    {instr_valid, user_mode, tb_tick, cr_load_en, xer_sum_load_en} = 5'h0;
    instr_word        = 32'h0;
    cr_load_data      = 32'h0;
    xer_sum_load_data = 4'h0;
    machine_state_reg = MSR_V;
    ack_delay         = 8'h02;
    sys_rst           = 1'b1;
    repeat (16) @(posedge clock);
    sys_rst <= 1'b0;
    t_cr();
    t_reads();
    t_dcr();
    t_tb();
    end_sim();
  end
endmodule
